/* File: rtl/ocdac_cfg.svh */
// constants of the octal converter command slave
`ifndef OCDAC_CFG_SVH
`define OCDAC_CFG_SVH
`define OCD_N_CHAN 8
`define OCD_RES 16
`define OCD_CMD_WR_IN 4'h0
`define OCD_CMD_UPD 4'h1
`define OCD_CMD_WR_UPD_ALL 4'h2
`define OCD_CMD_WR_UPD 4'h3
`define OCD_CMD_PD 4'h4
`define OCD_CMD_PD_CHIP 4'h5
`define OCD_CMD_REF_INT 4'h6
`define OCD_CMD_REF_EXT 4'h7
`define OCD_CMD_NOP 4'hf
`define OCD_CHAN_ALL 4'hf
`define OCD_GLOBAL_ADDR 7'h73
`define OCD_ZERO_CODE 16'h0000
`define OCD_MID_CODE 16'h8000
`define OCD_BIT_LAST 4'h7
`define OCD_BIT_ACK 4'h8
`define OCD_DATA_BYTES 2'h3
`define OCD_PRESET_AT 2'h2
`define OCD_PRESET_DONE 2'h3
`define OCD_TRIT_SQ 5'h9
`define OCD_TRIT 5'h3
`endif

/* File: rtl/ocdac_cmd_slave.sv */
// two-wire command slave and channel registers of the octal converter
`timescale 1ns/1ps
`default_nettype none
`include "ocdac_cfg.svh"

module ocdac_cmd_slave (
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_b_i,
    input  wire logic                                   scl_clk_i,
    input  wire logic                                   sda_i,
    output var  logic                                   sda_o,
    output var  logic                                   sda_oe_o,
    input  wire logic                                   async_load_pin_b_i,
    input  wire logic                                   power_on_level_select_i,
    input  wire logic                                   reference_comp_pin_i,
    input  wire logic [1:0]                             address_strap_0_i,
    input  wire logic [1:0]                             address_strap_1_i,
    input  wire logic [1:0]                             address_strap_2_i,
    output var  ocdac_pkg::ocdac_chan_t [`OCD_N_CHAN-1:0] chan_o,
    output var  ocdac_pkg::ocdac_ref_t                  ref_o
);
    import ocdac_pkg::*;

    function automatic logic [`OCD_N_CHAN-1:0] chan_mask(input logic [3:0] sel);
        chan_mask = '0;
        if (sel == `OCD_CHAN_ALL) begin
            chan_mask = '1;
        end else if (!sel[3]) begin
            chan_mask[sel[2:0]] = 1'b1;
        end
    endfunction : chan_mask

    // three-level straps: 00 ground, 01 open, 10 supply
    function automatic logic [6:0] strap_addr(input logic [5:0] s);
        logic [4:0] idx;
        idx = 5'(s[5:4]) * `OCD_TRIT_SQ + 5'(s[3:2]) * `OCD_TRIT + 5'(s[1:0]);
        strap_addr = {idx[4:2] + 3'h1, 2'b00, idx[1:0]};
    endfunction : strap_addr

    // link domain: one bit and a toggle per serial clock rise
    logic link_bit_ff;
    logic nxt_link_bit;
    logic link_tgl_ff;
    logic nxt_link_tgl;

    always_comb begin
        nxt_link_bit = sda_i;
        nxt_link_tgl = ~link_tgl_ff;
    end

    always_ff @(posedge scl_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            link_bit_ff <= 1'b0;
            link_tgl_ff <= 1'b0;
        end else begin
            link_bit_ff <= nxt_link_bit;
            link_tgl_ff <= nxt_link_tgl;
        end
    end

    // pins and the toggle enter clk_i through two flops; a third gives edges
    ocdac_pins_t pins_raw;
    ocdac_pins_t pins_meta_ff;
    ocdac_pins_t pins_ff;
    ocdac_pins_t pins_d_ff;

    assign pins_raw = {scl_clk_i, sda_i, async_load_pin_b_i, power_on_level_select_i,
                       reference_comp_pin_i, link_tgl_ff,
                       address_strap_2_i, address_strap_1_i, address_strap_0_i};

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pins_meta_ff <= '0;
            pins_ff      <= '0;
            pins_d_ff    <= '0;
        end else begin
            pins_meta_ff <= pins_raw;
            pins_ff      <= pins_meta_ff;
            pins_d_ff    <= pins_ff;
        end
    end

    logic start_evt;
    logic stop_evt;
    logic scl_fall;
    logic bit_evt;
    logic load_fall;

    // idle bus is high on both lines, so only these edges frame a transfer
    assign start_evt = pins_ff.scl & pins_d_ff.scl & pins_d_ff.sda & ~pins_ff.sda;
    assign stop_evt  = pins_ff.scl & pins_d_ff.scl & ~pins_d_ff.sda & pins_ff.sda;
    assign scl_fall  = pins_d_ff.scl & ~pins_ff.scl;
    // the sampled bit stays put until the next rise, long after this event
    assign bit_evt   = pins_ff.tgl ^ pins_d_ff.tgl;
    assign load_fall = pins_d_ff.load_b & ~pins_ff.load_b;

    // byte engine
    ocdac_state_t        st_ff;
    ocdac_state_t        nxt_st;
    logic [3:0]          cnt_ff;
    logic [3:0]          nxt_cnt;
    logic [7:0]          sr_ff;
    logic [7:0]          nxt_sr;
    logic [1:0]          bidx_ff;
    logic [1:0]          nxt_bidx;
    logic [7:0]          cmd_ff;
    logic [7:0]          nxt_cmd;
    logic [7:0]          hi_ff;
    logic [7:0]          nxt_hi;
    logic [15:0]         dw_ff;
    logic [15:0]         nxt_dw;
    logic                pend_ff;
    logic                nxt_pend;
    logic                oe_ff;
    logic                nxt_oe;
    logic                exec_ff;
    logic                nxt_exec;
    logic [7:0]          nb;

    assign nb = {sr_ff[6:0], link_bit_ff};

    always_comb begin
        nxt_st   = st_ff;
        nxt_cnt  = cnt_ff;
        nxt_sr   = sr_ff;
        nxt_bidx = bidx_ff;
        nxt_cmd  = cmd_ff;
        nxt_hi   = hi_ff;
        nxt_dw   = dw_ff;
        nxt_pend = pend_ff;
        nxt_oe   = oe_ff;
        nxt_exec = 1'b0;
        if (stop_evt) begin
            nxt_st   = ST_IDLE;
            nxt_oe   = 1'b0;
            nxt_pend = 1'b0;
        end else if (start_evt) begin
            nxt_st   = ST_ADDR;
            nxt_cnt  = '0;
            nxt_bidx = '0;
            nxt_oe   = 1'b0;
            nxt_pend = 1'b0;
        end else begin
            if (scl_fall && cnt_ff == `OCD_BIT_ACK && pend_ff) begin
                nxt_oe = 1'b1;
            end else if (scl_fall && cnt_ff == '0) begin
                nxt_oe   = 1'b0;
                nxt_pend = 1'b0;
            end
            if (bit_evt && st_ff != ST_IDLE) begin
                if (cnt_ff == `OCD_BIT_ACK) begin
                    nxt_cnt = '0;
                    if (st_ff == ST_ADDR) begin
                        nxt_st = pend_ff ? ST_DATA : ST_IGNORE;
                    end
                end else begin
                    nxt_sr  = nb;
                    nxt_cnt = cnt_ff + 4'h1;
                    if (cnt_ff == `OCD_BIT_LAST) begin
                        unique case (st_ff)
                            ST_ADDR: begin
                                nxt_pend = ~nb[0] & (nb[7:1] == `OCD_GLOBAL_ADDR
                                           | nb[7:1] == strap_addr(pins_ff.strap));
                            end
                            ST_DATA: begin
                                nxt_pend = bidx_ff != `OCD_DATA_BYTES;
                                unique case (bidx_ff)
                                    2'h0: nxt_cmd = nb;
                                    2'h1: nxt_hi = nb;
                                    2'h2: begin
                                        nxt_dw   = {hi_ff, nb};
                                        nxt_exec = 1'b1;
                                    end
                                    2'h3: nxt_pend = 1'b0;
                                endcase
                                if (bidx_ff != `OCD_DATA_BYTES) begin
                                    nxt_bidx = bidx_ff + 2'h1;
                                end
                            end
                            default: nxt_pend = 1'b0;
                        endcase
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff   <= ST_IDLE;
            cnt_ff  <= '0;
            sr_ff   <= '0;
            bidx_ff <= '0;
            cmd_ff  <= {`OCD_CMD_NOP, `OCD_CHAN_ALL};
            hi_ff   <= '0;
            dw_ff   <= '0;
            pend_ff <= 1'b0;
            oe_ff   <= 1'b0;
            exec_ff <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            cnt_ff  <= nxt_cnt;
            sr_ff   <= nxt_sr;
            bidx_ff <= nxt_bidx;
            cmd_ff  <= nxt_cmd;
            hi_ff   <= nxt_hi;
            dw_ff   <= nxt_dw;
            pend_ff <= nxt_pend;
            oe_ff   <= nxt_oe;
            exec_ff <= nxt_exec;
        end
    end

    // open drain: only ever pulls low
    assign sda_o    = 1'b0;
    assign sda_oe_o = oe_ff;

    // command decode, reference, load arming and power-on preset
    logic [3:0]             cmd;
    logic [`OCD_N_CHAN-1:0] mask;
    logic                   wr_in;
    logic                   upd_sel;
    logic                   upd_all;
    logic                   pd_sel;
    logic                   pd_chip;
    logic                   load_go;
    logic                   preset_go;
    logic                   armed_ff;
    logic                   nxt_armed;
    logic [1:0]             pre_cnt_ff;
    logic [1:0]             nxt_pre_cnt;
    logic                   ref_on_ff;
    logic                   nxt_ref_on;
    logic                   ref_ext_ff;
    logic                   nxt_ref_ext;
    logic                   chip_pd_ff;
    logic                   nxt_chip_pd;

    assign cmd       = cmd_ff[7:4];
    assign mask      = chan_mask(cmd_ff[3:0]);
    assign preset_go = pre_cnt_ff == `OCD_PRESET_AT;
    assign load_go   = load_fall & armed_ff;

    // reserved command codes, and the nop, change no register but still arm the load pin
    always_comb begin
        wr_in   = exec_ff & (cmd == `OCD_CMD_WR_IN | cmd == `OCD_CMD_WR_UPD_ALL
                  | cmd == `OCD_CMD_WR_UPD);
        upd_sel = exec_ff & (cmd == `OCD_CMD_UPD | cmd == `OCD_CMD_WR_UPD);
        upd_all = (exec_ff & cmd == `OCD_CMD_WR_UPD_ALL) | load_go;
        pd_sel  = exec_ff & cmd == `OCD_CMD_PD;
        pd_chip = exec_ff & cmd == `OCD_CMD_PD_CHIP;
        nxt_pre_cnt = (pre_cnt_ff == `OCD_PRESET_DONE) ? pre_cnt_ff : pre_cnt_ff + 2'h1;
        nxt_armed   = (armed_ff & ~load_go) | exec_ff;
        nxt_ref_on  = ref_on_ff;
        nxt_ref_ext = ref_ext_ff;
        nxt_chip_pd = chip_pd_ff;
        // a chip-wide power-down is undone by any update; external select is not
        if (chip_pd_ff & (upd_all | (upd_sel & |mask))) begin
            nxt_ref_on  = 1'b1;
            nxt_chip_pd = 1'b0;
        end
        if (pd_chip) begin
            nxt_ref_on  = 1'b0;
            nxt_chip_pd = 1'b1;
        end
        if (exec_ff & cmd == `OCD_CMD_REF_INT) begin
            nxt_ref_on  = 1'b1;
            nxt_ref_ext = 1'b0;
            nxt_chip_pd = 1'b0;
        end
        if (exec_ff & cmd == `OCD_CMD_REF_EXT) begin
            nxt_ref_on  = 1'b0;
            nxt_ref_ext = 1'b1;
            nxt_chip_pd = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            armed_ff   <= 1'b0;
            pre_cnt_ff <= '0;
            ref_on_ff  <= 1'b1;
            ref_ext_ff <= 1'b0;
            chip_pd_ff <= 1'b0;
        end else begin
            armed_ff   <= nxt_armed;
            pre_cnt_ff <= nxt_pre_cnt;
            ref_on_ff  <= nxt_ref_on;
            ref_ext_ff <= nxt_ref_ext;
            chip_pd_ff <= nxt_chip_pd;
        end
    end

    // a grounded compensation pin turns the reference pin into an input only
    assign ref_o = '{int_on: ref_on_ff, ext_sel: ref_ext_ff,
                     io_input: ref_ext_ff | ~pins_ff.reference_comp_pin};

    genvar g;
    generate
        for (g = 0; g < `OCD_N_CHAN; g++) begin : gen_chan
            logic [`OCD_RES-1:0] in_ff;
            logic [`OCD_RES-1:0] nxt_in;
            ocdac_chan_t         ch_ff;
            ocdac_chan_t         nxt_ch;

            always_comb begin
                nxt_in = in_ff;
                nxt_ch = ch_ff;
                if (preset_go) begin
                    nxt_in      = pins_ff.power_on_level_select ? `OCD_MID_CODE : `OCD_ZERO_CODE;
                    nxt_ch.code = nxt_in;
                end else begin
                    if (wr_in & mask[g]) begin
                        nxt_in = dw_ff[15 -: `OCD_RES];
                    end
                    if (upd_all | (upd_sel & mask[g])) begin
                        nxt_ch.code = nxt_in;
                        nxt_ch.pd   = 1'b0;
                    end
                    if (pd_chip | (pd_sel & mask[g])) begin
                        nxt_ch.pd = 1'b1;
                    end
                end
            end

            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    in_ff <= '0;
                    ch_ff <= '0;
                end else begin
                    in_ff <= nxt_in;
                    ch_ff <= nxt_ch;
                end
            end

            assign chan_o[g] = ch_ff;
        end
    endgenerate

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    preset_code_a: assert property (preset_go |=> chan_o[0].code ==
        ($past(pins_ff.power_on_level_select) ? `OCD_MID_CODE : `OCD_ZERO_CODE)) else $error("bad preset");
    ref_default_a: assert property (pre_cnt_ff != `OCD_PRESET_DONE |-> ref_o.int_on)
        else $error("reference not on at start-up");
    write_only_a: assert property (exec_ff && cmd == `OCD_CMD_WR_IN && !load_go
        |=> $stable(chan_o)) else $error("input write changed a channel");
    update_pu_a: assert property (exec_ff && cmd == `OCD_CMD_UPD && cmd_ff[3:0] == '0
        |=> !chan_o[0].pd) else $error("update left channel powered down");
    chip_down_a: assert property (exec_ff && cmd == `OCD_CMD_PD_CHIP
        |=> chan_o[0].pd && chan_o[7].pd && !ref_o.int_on) else $error("chip not down");
    ref_int_a: assert property (exec_ff && cmd == `OCD_CMD_REF_INT
        |=> ref_o.int_on && !ref_o.ext_sel) else $error("internal reference not selected");
    ref_ext_a: assert property (exec_ff && cmd == `OCD_CMD_REF_EXT
        |=> !ref_o.int_on && ref_o.ext_sel) else $error("external reference not selected");
    start_take_a: assert property (start_evt |=> st_ff == ST_ADDR && cnt_ff == '0)
        else $error("start not taken");
    stop_free_a: assert property (stop_evt |=> st_ff == ST_IDLE && !sda_oe_o)
        else $error("stop not taken");
    ack_hold_a: assert property (sda_oe_o && pins_ff.scl |=> sda_oe_o || !pins_ff.scl)
        else $error("ack released while clock high");
    ack_cause_a: assert property ($rose(sda_oe_o) |-> $past(pend_ff)
        && $past(cnt_ff) == `OCD_BIT_ACK) else $error("ack without accepted byte");
    read_quiet_a: assert property (st_ff == ST_IGNORE |-> !sda_oe_o)
        else $error("read acknowledged");
    extra_nak_a: assert property (st_ff == ST_DATA && bidx_ff == `OCD_DATA_BYTES && bit_evt
        && cnt_ff == `OCD_BIT_LAST |=> !pend_ff) else $error("extra byte accepted");
    load_idle_a: assert property (load_fall && !armed_ff && !exec_ff
        |=> $stable(chan_o)) else $error("load without full write");

    exec_seen_c: cover property (exec_ff);
    load_seen_c: cover property (load_go);
    // a whole frame outlasts the delay limit, so only its closing part is covered
    frame_c: cover property (exec_ff ##[1:1000] stop_evt);
endmodule : ocdac_cmd_slave
`default_nettype wire

/* File: rtl/ocdac_pkg.sv */
// types of the octal converter command slave
`include "ocdac_cfg.svh"
package ocdac_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_IGNORE} ocdac_state_t;
    typedef struct packed {
        logic                pd;
        logic [`OCD_RES-1:0] code;
    } ocdac_chan_t;
    typedef struct packed {
        logic int_on;
        logic ext_sel;
        logic io_input;
    } ocdac_ref_t;
    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       load_b;
        logic       power_on_level_select;
        logic       reference_comp_pin;
        logic       tgl;
        logic [5:0] strap;
    } ocdac_pins_t;
endpackage : ocdac_pkg

/* File: tb/ocdac_bus_master.sv */
// two-wire bus master model that drives frames into the command slave
`timescale 1ns/1ps
`default_nettype none
module ocdac_bus_master (
    output var  logic scl_o,
    output var  logic sda_pull_o,
    input  wire logic sda_i
);
    localparam realtime QTR = 40.0;
    // idle bus: clock high, data released to its pull-up
    initial begin
        scl_o      = 1'b1;
        sda_pull_o = 1'b0;
    end
    // data changes mid-low, so it never moves while the clock is high
    task automatic put_bit(input logic b, output logic seen);
        #QTR sda_pull_o = ~b;
        #QTR scl_o = 1'b1;
        #QTR seen = sda_i;
        #QTR scl_o = 1'b0;
    endtask : put_bit
    task automatic frame(input logic [7:0] abyte, input logic [31:0] data,
                         input int n_data, output logic [4:0] acks);
        logic [39:0] sr;
        logic        seen;
        sr   = {abyte, data};
        acks = 5'h00;
        // odd offset keeps the link edges off the system clock grid
        #13.7;
        sda_pull_o = 1'b1;
        #(2 * QTR) scl_o = 1'b0;
        for (int k = 0; k <= n_data; k++) begin
            for (int j = 0; j < 8; j++) begin
                put_bit(sr[39], seen);
                sr = sr << 1;
            end
            put_bit(1'b1, seen);
            acks[k] = ~seen;
        end
        #QTR sda_pull_o = 1'b1;
        #QTR scl_o = 1'b1;
        #QTR sda_pull_o = 1'b0;
        #(4 * QTR);
    endtask : frame
endmodule : ocdac_bus_master
`default_nettype wire

/* File: tb/ocdac_cmd_slave_test.sv */
// self-checking bench of the octal converter command slave
`timescale 1ns/1ps
`default_nettype none
`include "ocdac_cfg.svh"
module ocdac_cmd_slave_test;
    import ocdac_pkg::*;
    logic                               clk_i;
    logic                               rst_b_i;
    logic                               scl;
    logic                               sda_pull;
    wire logic                          sda_w;
    logic                               sda_o;
    logic                               sda_oe;
    logic                               load_b;
    logic                               power_on_level_select;
    logic                               reference_comp_pin;
    logic [1:0]                         s0;
    logic [1:0]                         s1;
    logic [1:0]                         s2;
    ocdac_chan_t [`OCD_N_CHAN-1:0]      chan_o;
    ocdac_ref_t                         ref_o;
    logic [15:0]                        lfsr_q;
    logic [6:0]                         own;
    logic [15:0]                        in_m  [8];
    logic [15:0]                        dac_m [8];
    logic [7:0]                         pd_m;
    logic                               int_m;
    logic                               ext_m;
    logic                               chip_m;
    int                                 bad_count;
    int                                 n_compared;
    logic [3:0] cmd_tab [9] = '{`OCD_CMD_WR_IN, `OCD_CMD_UPD, `OCD_CMD_WR_UPD_ALL,
        `OCD_CMD_WR_UPD, `OCD_CMD_PD, `OCD_CMD_PD_CHIP, `OCD_CMD_REF_INT,
        `OCD_CMD_REF_EXT, `OCD_CMD_NOP};
    // open drain wire with pull-up
    assign sda_w = ~(sda_pull | (sda_oe & ~sda_o));
    always #2 clk_i = ~clk_i;
    ocdac_bus_master ocdac_bus_master_i (.scl_o(scl), .sda_pull_o(sda_pull), .sda_i(sda_w));
    ocdac_cmd_slave ocdac_cmd_slave_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_clk_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .async_load_pin_b_i(load_b), .power_on_level_select_i(power_on_level_select),
        .reference_comp_pin_i(reference_comp_pin), .address_strap_0_i(s0), .address_strap_1_i(s1),
        .address_strap_2_i(s2), .chan_o(chan_o), .ref_o(ref_o));
    function automatic logic [15:0] lfsr_next();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q;
    endfunction : lfsr_next
    function automatic void upd(input int i);
        dac_m[i] = in_m[i];
        pd_m[i]  = 1'b0;
        // reference dropped by chip power-down comes back with any update
        int_m    = int_m | chip_m;
        chip_m   = 1'b0;
    endfunction : upd
    function automatic void model_cmd(input logic [3:0] c, input logic [3:0] ch,
                                      input logic [15:0] w);
        logic sel;
        for (int i = 0; i < 8; i++) begin
            sel = (ch == `OCD_CHAN_ALL) || (ch == i[3:0]);
            if (sel && (c == 4'h0 || c == 4'h2 || c == 4'h3)) in_m[i] = w;
            if (sel && (c == 4'h1 || c == 4'h3)) upd(i);
            if (sel && c == 4'h4) pd_m[i] = 1'b1;
        end
        for (int i = 0; i < 8; i++) begin
            if (c == 4'h2) upd(i);
        end
        case (c)
            4'h5: begin
                pd_m   = 8'hff;
                int_m  = 1'b0;
                chip_m = 1'b1;
            end
            4'h6: begin
                int_m  = 1'b1;
                ext_m  = 1'b0;
                chip_m = 1'b0;
            end
            4'h7: begin
                int_m  = 1'b0;
                ext_m  = 1'b1;
                chip_m = 1'b0;
            end
            default: ;
        endcase
    endfunction : model_cmd
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic check_all();
        for (int i = 0; i < 8; i++) begin
            check("code", 32'(chan_o[i].code), 32'(dac_m[i]));
            check("pd", 32'(chan_o[i].pd), 32'(pd_m[i]));
        end
        check("ref", 32'(ref_o), 32'({int_m, ext_m, ext_m | ~reference_comp_pin}));
    endtask : check_all
    task automatic send(input logic [6:0] a, input logic rd, input logic [31:0] d,
                        input int n, input logic [4:0] exp_ack);
        logic [4:0] acks;
        ocdac_bus_master_i.frame({a, rd}, d, n, acks);
        check("ack", 32'(acks), 32'(exp_ack));
        repeat (10) @(negedge clk_i);
    endtask : send
    task automatic cmd(input logic [3:0] c, input logic [3:0] ch, input logic [15:0] w,
                       input logic glob);
        send(glob ? `OCD_GLOBAL_ADDR : own, 1'b0, {c, ch, w, 8'h00}, 3, 5'h0f);
        model_cmd(c, ch, w);
        check_all();
    endtask : cmd
    task automatic do_reset(input logic mid);
        logic [15:0] r;
        int          idx;
        @(negedge clk_i);
        rst_b_i = 1'b0;
        r       = lfsr_next();
        power_on_level_select  = mid;
        reference_comp_pin = mid;
        s0      = 2'(r[2:1] % 3);
        s1      = 2'(r[4:3] % 3);
        s2      = 2'(r[6:5] % 3);
        repeat (3) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (10) @(negedge clk_i);
        idx = s2 * 9 + s1 * 3 + s0;
        own = {3'(idx[4:2] + 1), 2'b00, idx[1:0]};
        for (int i = 0; i < 8; i++) begin
            in_m[i]  = mid ? `OCD_MID_CODE : `OCD_ZERO_CODE;
            dac_m[i] = in_m[i];
        end
        pd_m   = 8'h00;
        int_m  = 1'b1;
        ext_m  = 1'b0;
        chip_m = 1'b0;
        check_all();
    endtask : do_reset
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #300us;
        bad_count++;
        print_verdict();
    end
    initial begin
        logic [15:0] r;
        clk_i      = 1'b0;
        rst_b_i    = 1'b0;
        load_b     = 1'b1;
        power_on_level_select     = 1'b0;
        reference_comp_pin    = 1'b0;
        {s0, s1, s2} = 6'h00;
        lfsr_q     = 16'h0055;
        bad_count  = 0;
        n_compared = 0;
        do_reset(1'b0);
        send(own ^ 7'h08, 1'b0, 32'h3f12_3400, 3, 5'h00);
        send(own, 1'b1, 32'h0000_0000, 0, 5'h00);
        check_all();
        // fourth data byte must go unanswered, command still runs
        send(`OCD_GLOBAL_ADDR, 1'b0, 32'h3f12_3400, 4, 5'h0f);
        model_cmd(4'h3, 4'hf, 16'h1234);
        check_all();
        send(own, 1'b0, 32'h3fab_cd00, 2, 5'h07);
        check_all();
        for (int i = 0; i < 9; i++) begin
            cmd(cmd_tab[i], 4'(i % 8), lfsr_next(), i[0]);
        end
        cmd(4'h5, 4'h0, 16'h0000, 1'b0);
        cmd(4'h1, 4'h2, 16'h0000, 1'b0);
        for (int n = 0; n < 16; n++) begin
            r = lfsr_next();
            cmd(cmd_tab[r % 9], (r[7:5] == 3'h0) ? `OCD_CHAN_ALL : {1'b0, r[10:8]},
                lfsr_next(), r[11]);
        end
        cmd(4'h4, 4'h1, 16'h0000, 1'b0);
        cmd(4'h0, 4'h0, 16'hbeef, 1'b0);
        load_b = 1'b0;
        repeat (10) @(negedge clk_i);
        for (int i = 0; i < 8; i++) begin
            upd(i);
        end
        check_all();
        load_b = 1'b1;
        repeat (10) @(negedge clk_i);
        // second fall with no write since the last load must not update
        cmd(4'h4, 4'h3, 16'h0000, 1'b0);
        cmd(4'h0, 4'h3, 16'h5a5a, 1'b0);
        load_b = 1'b0;
        repeat (10) @(negedge clk_i);
        for (int i = 0; i < 8; i++) begin
            upd(i);
        end
        check_all();
        load_b = 1'b1;
        repeat (10) @(negedge clk_i);
        load_b = 1'b0;
        repeat (10) @(negedge clk_i);
        check_all();
        load_b = 1'b1;
        repeat (10) @(negedge clk_i);
        do_reset(1'b1);
        cmd(4'h3, 4'h7, 16'hffff, 1'b1);
        print_verdict();
    end
endmodule : ocdac_cmd_slave_test
`default_nettype wire
